// File: audio_dac_mode_control_regs.sv
// mode control registers, serial control port slave and zero-flag detection
// assumes pins arrive asynchronously; sample_zero and soft_mute_request are on clk_sys
// How it works
// - phase invert flips both output polarities
// - step rate divides frame clock by 1,2,4,8
// - output disable forces bipolar zero level
// - pin select turns bitstream pins into flags
// - bypass stereo select picks pins for stereo
// - rolloff select: sharp at zero, slow at one
// - zero mute after 1024 zero samples, both
// - zero mute inactive in bitstream mode
// - soft reset write-only, one pulse, defaults
// - bitstream enable selects one-bit input mode
// - external filter bypass skips internal filter
// - single-channel mode drives both converters balanced
// - mono source: left zero, right one
// - modulator rate 64,32,128 times, 11 reserved
// - bitstream mode: rate selects bit clock
// - zero mode: off, balanced, fixed pattern
// - bitstream flags: balanced bytes or 96h 200ms
// - pcm flags after 1024 zero ticks
// - direction bit: zero writes, one reads
// - zero status bits read back flags
// - soft mute ramps 255 steps at rate
`default_nettype none
module audio_dac_mode_control_regs
    import audio_dac_mode_pkg::*;
#(
    parameter logic [TIMER_W-1:0] PATTERN_HOLD = TIMER_W'(PATTERN_HOLD_CYCLES)
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ctl_clock,
    input  wire logic       ctl_select_n,
    input  wire logic       ctl_data_in,
    output logic            ctl_data_out,
    output logic            ctl_data_oe,
    input  wire logic       sample_frame_clock,
    input  wire logic       filter_word_clock,
    input  wire logic       bitstream_bit_clock,
    input  wire logic       left_bitstream_pin_in,
    output logic            left_bitstream_pin_out,
    output logic            left_bitstream_pin_oe,
    input  wire logic       right_bitstream_pin_in,
    output logic            right_bitstream_pin_out,
    output logic            right_bitstream_pin_oe,
    input  wire logic [1:0] sample_zero,
    input  wire logic       soft_mute_request,
    output ctrl_t           ctrl,
    output logic            force_bipolar_zero,
    output logic            zero_detect_mute,
    output logic            soft_reset_pulse,
    output logic            atten_step_tick,
    output logic [7:0]      mute_ramp_level,
    output logic [1:0]      bitstream_clock_select
);
    // whole module state
    typedef struct packed {
        logic [7:0]              s1;         // first sync stage, read by s2 only
        logic [7:0]              s2;         // synchronised pins
        logic [7:0]              s3;         // previous s2, for edges
        ser_state_t              ser;        // serial sequencer
        logic [4:0]              bit_cnt;    // rising edges seen in word
        logic [15:0]             shift_in;   // incoming word
        logic [7:0]              shift_out;  // read-back data
        logic                    rd;         // current word is a read
        logic [7:0]              reg_oc;     // output_control
        logic [7:0]              reg_msb;    // mode_select_b
        logic [7:0]              reg_zfc;    // zero_flag_config
        logic [1:0][10:0]        zcnt;       // zero sample run per channel
        logic [1:0][7:0]         bs_shift;   // bitstream groups
        logic [2:0]              bs_cnt;     // bit position in group
        logic [1:0]              bs_even;    // last group balanced
        logic [1:0]              pat_ok;     // last group was idle pattern
        logic [1:0][TIMER_W-1:0] pat_timer;  // idle pattern duration
        logic [1:0]              zflag;      // zero flags
        logic [2:0]              frame_div;  // step rate divider
        ctrl_t                   ctrl;
        logic                    force_zero;
        logic                    zmute;
        logic                    soft_system_reset;
        logic                    step_tick;
        logic [7:0]              ramp;
        logic [1:0]              bs_rate;
        logic [1:0]              pin_out;
        logic [1:0]              pin_oe;
        logic                    sdo;
        logic                    sdo_oe;
    } state_t;

    state_t st;
    state_t next_st;

    // temporaries shared with the checks below
    logic        wr_now;
    logic [6:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        soft_now;

    // ones in a bitstream group
    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // read-back value of an index; unmapped reads as zero
    function automatic logic [7:0] read_reg(input state_t s, input logic [6:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == IDX_OUTPUT_CONTROL) begin
            v = s.reg_oc;
        end else if (idx == IDX_MODE_SELECT_B) begin
            v = s.reg_msb;
        end else if (idx == IDX_ZERO_FLAG_CONFIG) begin
            v = s.reg_zfc;
        end else if (idx == IDX_ZERO_FLAG_STATUS) begin
            v = {6'h00, s.zflag[1], s.zflag[0]};
        end
        return v;
    endfunction

    // next-state logic
    always_comb begin
        logic       sclk_rise;
        logic       sclk_fall;
        logic       sel;
        logic       din;
        logic       frame_tick;
        logic       word_tick;
        logic       bclk_rise;
        logic       pcm_tick;
        logic       bs_mode;
        logic [2:0] mask;
        logic [1:0] zsat;
        logic [7:0] grp;
        logic [15:0] word;
        logic       target;
        next_st    = st;
        wr_now     = 1'b0;
        wr_idx     = 7'h00;
        wr_data    = 8'h00;
        soft_now   = 1'b0;
        word       = 16'h0000;
        grp        = 8'h00;
        zsat       = 2'b00;
        mask       = 3'h0;
        pcm_tick   = 1'b0;
        target     = 1'b0;
        next_st.s1 = {right_bitstream_pin_in, left_bitstream_pin_in, bitstream_bit_clock,
                      filter_word_clock, sample_frame_clock, ctl_data_in, ctl_select_n,
                      ctl_clock};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        sclk_rise  = st.s2[0] & ~st.s3[0];
        sclk_fall  = ~st.s2[0] & st.s3[0];
        sel        = ~st.s2[1];
        din        = st.s2[2];
        frame_tick = st.s2[3] & ~st.s3[3];
        word_tick  = st.s2[4] & ~st.s3[4];
        bclk_rise  = st.s2[5] & ~st.s3[5];
        bs_mode    = st.ctrl.bitstream_interface_enable;
        next_st.soft_system_reset = 1'b0;

        // serial control port: 16 bits, msb first, sampled on rising clock
        case (st.ser)
            SER_IDLE: begin
                if (sel) begin
                    next_st.ser     = SER_SHIFT;
                    next_st.bit_cnt = 5'h00;
                    next_st.rd      = 1'b0;
                end
            end
            SER_SHIFT: begin
                if (!sel) begin
                    // word cut short: nothing is committed
                    next_st.ser = SER_IDLE;
                end else if (sclk_rise) begin
                    next_st.shift_in = {st.shift_in[14:0], din};
                    next_st.bit_cnt  = st.bit_cnt + 5'h01;
                    if (st.bit_cnt == CNT_HEAD_LAST) begin
                        next_st.rd        = st.shift_in[6];
                        next_st.shift_out = read_reg(st, {st.shift_in[5:0], din});
                    end
                    if (st.bit_cnt == CNT_WORD_LAST) begin
                        word        = {st.shift_in[14:0], din};
                        next_st.ser = SER_DONE;
                        // write only when bit is zero
                        wr_now  = ~word[WORD_DIR_BIT];
                        wr_idx  = word[14:8];
                        wr_data = word[7:0];
                    end
                end else if (sclk_fall && st.rd && st.bit_cnt >= CNT_DATA_FIRST) begin
                    // data changes on falling edge, host samples on rising
                    next_st.sdo       = st.shift_out[7];
                    next_st.shift_out = {st.shift_out[6:0], 1'b0};
                end
            end
            SER_DONE: begin
                if (!sel) begin
                    next_st.ser = SER_IDLE;
                end
            end
            default: begin
                next_st.ser = SER_IDLE;
            end
        endcase
        next_st.sdo_oe = sel && st.rd && (st.ser != SER_IDLE) && st.bit_cnt >= CNT_DATA_FIRST;

        // register writes
        if (wr_now) begin
            if (wr_idx == IDX_OUTPUT_CONTROL) begin
                next_st.reg_oc = wr_data;
            end else if (wr_idx == IDX_MODE_SELECT_B) begin
                // reserved bit and reserved rate code ignored
                next_st.reg_msb[7:2] = {2'b00, wr_data[5:2]};
                if (wr_data[1:0] != RATE_RESERVED) begin
                    next_st.reg_msb[1:0] = wr_data[1:0];
                end
                soft_now = wr_data[MS_SRESET];
            end else if (wr_idx == IDX_ZERO_FLAG_CONFIG) begin
                next_st.reg_zfc = {5'h00, wr_data[2:0]};
            end
        end

        // pcm zero run, frame or word clock
        pcm_tick = st.ctrl.external_filter_bypass ? word_tick : frame_tick;
        for (int c = 0; c < 2; c++) begin
            zsat[c] = (st.zcnt[c] == ZERO_RUN);
            if (bs_mode) begin
                next_st.zcnt[c] = 11'h000;
            end else if (pcm_tick) begin
                if (!sample_zero[c]) begin
                    next_st.zcnt[c] = 11'h000;
                end else if (!zsat[c]) begin
                    next_st.zcnt[c] = st.zcnt[c] + 11'h001;
                end
            end
        end

        if (bs_mode && bclk_rise && !st.ctrl.zero_flag_pin_select) begin
            next_st.bs_cnt = st.bs_cnt + 3'h1;
            for (int c = 0; c < 2; c++) begin
                grp = {st.bs_shift[c][6:0], st.s2[6 + c]};
                next_st.bs_shift[c] = grp;
                if (st.bs_cnt == GROUP_LAST) begin
                    next_st.bs_even[c] = (ones(grp) == BALANCED_ONES);
                    next_st.pat_ok[c]  = (grp == IDLE_PATTERN);
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            // idle pattern must persist for the hold time
            if (!bs_mode || !st.pat_ok[c]) begin
                next_st.pat_timer[c] = '0;
            end else if (st.pat_timer[c] != PATTERN_HOLD) begin
                next_st.pat_timer[c] = st.pat_timer[c] + TIMER_W'(1);
            end
            if (bs_mode) begin
                if (st.ctrl.bitstream_zero_flag_mode == BSZ_OFF) begin
                    next_st.zflag[c] = 1'b0;
                end else if (st.ctrl.bitstream_zero_flag_mode[1]) begin
                    next_st.zflag[c] = (st.pat_timer[c] == PATTERN_HOLD);
                end else begin
                    next_st.zflag[c] = st.bs_even[c];
                end
            end else begin
                next_st.zflag[c] = st.ctrl.pcm_zero_flag_enable & zsat[c];
            end
        end

        // mute on long zero run, not in bitstream mode
        next_st.zmute = st.ctrl.zero_detect_mute_enable & ~bs_mode & zsat[0] & zsat[1];
        next_st.force_zero = st.ctrl.output_disable | st.zmute;

        mask = 3'((4'h1 << st.ctrl.atten_step_rate) - 4'h1);
        next_st.step_tick = 1'b0;
        if (frame_tick) begin
            next_st.frame_div = st.frame_div + 3'h1;
            next_st.step_tick = ((st.frame_div & mask) == 3'h0);
        end
        // soft mute ramp, one level per step
        target = soft_mute_request | st.zmute;
        if (st.step_tick) begin
            if (target && st.ramp != 8'h00) begin
                next_st.ramp = st.ramp - 8'h01;
            end else if (!target && st.ramp != RAMP_TOP) begin
                next_st.ramp = st.ramp + 8'h01;
            end
        end

        // pins carry zero flags when selected
        next_st.pin_oe  = {2{st.ctrl.zero_flag_pin_select}};
        next_st.pin_out = st.ctrl.zero_flag_pin_select ? st.zflag : 2'b00;
        // rate doubles as bit clock select
        next_st.bs_rate = bs_mode ? st.ctrl.modulator_rate_select : 2'b00;

        // soft reset restores defaults, one pulse
        if (soft_now) begin
            next_st.soft_system_reset      = 1'b1;
            next_st.reg_oc    = RST_OUTPUT_CONTROL;
            next_st.reg_msb   = RST_MODE_SELECT_B;
            next_st.reg_zfc   = RST_ZERO_FLAG_CONFIG;
            next_st.zcnt      = '0;
            next_st.pat_ok    = 2'b00;
            next_st.bs_even   = 2'b00;
            next_st.zflag     = 2'b00;
            next_st.ramp      = RAMP_TOP;
        end

        // decode settings
        next_st.ctrl.output_phase_invert        = next_st.reg_oc[OC_PHASE];
        next_st.ctrl.atten_step_rate            = next_st.reg_oc[OC_RATE +: 2];
        next_st.ctrl.output_disable             = next_st.reg_oc[OC_DISABLE];
        next_st.ctrl.zero_flag_pin_select       = next_st.reg_oc[OC_PINSEL];
        next_st.ctrl.bypass_stereo_select       = next_st.reg_oc[OC_STEREO];
        next_st.ctrl.filter_rolloff_select      = next_st.reg_oc[OC_ROLLOFF];
        next_st.ctrl.zero_detect_mute_enable    = next_st.reg_oc[OC_ZMUTE];
        next_st.ctrl.bitstream_interface_enable = next_st.reg_msb[MS_BSTREAM];
        next_st.ctrl.external_filter_bypass     = next_st.reg_msb[MS_EXTFILT];
        next_st.ctrl.single_channel             = next_st.reg_msb[MS_SINGLE];
        // channel choice only in single-channel mode
        next_st.ctrl.mono_source_channel = next_st.reg_msb[MS_MONOSRC] &
                                           next_st.reg_msb[MS_SINGLE];
        next_st.ctrl.modulator_rate_select      = next_st.reg_msb[MS_RATE +: 2];
        next_st.ctrl.bitstream_zero_flag_mode   = next_st.reg_zfc[ZC_BSMODE +: 2];
        next_st.ctrl.pcm_zero_flag_enable       = next_st.reg_zfc[ZC_PCMEN];
    end

    // state register; everything resets to constants
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st                           <= '0;
            // pin stages start at idle: select and control clock high, no false edge
            st.s1                        <= 8'h03;
            st.s2                        <= 8'h03;
            st.s3                        <= 8'h03;
            st.reg_zfc                   <= RST_ZERO_FLAG_CONFIG;
            st.ctrl.pcm_zero_flag_enable <= 1'b1;
            st.ramp                      <= RAMP_TOP;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign ctl_data_out            = st.sdo;
    assign ctl_data_oe             = st.sdo_oe;
    assign left_bitstream_pin_out  = st.pin_out[0];
    assign left_bitstream_pin_oe   = st.pin_oe[0];
    assign right_bitstream_pin_out = st.pin_out[1];
    assign right_bitstream_pin_oe  = st.pin_oe[1];
    assign ctrl                    = st.ctrl;
    assign force_bipolar_zero      = st.force_zero;
    assign zero_detect_mute        = st.zmute;
    assign soft_reset_pulse        = st.soft_system_reset;
    assign atten_step_tick         = st.step_tick;
    assign mute_ramp_level         = st.ramp;
    assign bitstream_clock_select  = st.bs_rate;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_phase_write_lands: assert property (
        (wr_now && wr_idx == IDX_OUTPUT_CONTROL) |=> ctrl.output_phase_invert == $past(wr_data[7])
    ) else $error("phase invert did not follow a write");
    a_step_spacing: assert property (
        (atten_step_tick && ctrl.atten_step_rate == 2'b11) |=> !atten_step_tick [*8]
    ) else $error("step ticks closer than the divide by eight allows");
    a_disable_forces_zero: assert property (
        ctrl.output_disable |=> force_bipolar_zero
    ) else $error("output disable did not force bipolar zero");
    a_pin_turnaround: assert property (
        ctrl.zero_flag_pin_select |=> (left_bitstream_pin_oe && right_bitstream_pin_oe)
    ) else $error("flag pins not driven while selected");
    a_no_mute_bitstream: assert property (
        ctrl.bitstream_interface_enable |=> !zero_detect_mute
    ) else $error("zero mute active in bitstream mode");
    a_soft_reset_single: assert property (
        soft_reset_pulse |=> (!soft_reset_pulse && ctrl == ctrl_t'(15'h0001))
    ) else $error("soft reset pulse too long or settings not restored");
    a_rate_reserved_kept: assert property (
        (wr_now && wr_idx == IDX_MODE_SELECT_B && wr_data[1:0] == RATE_RESERVED &&
            !wr_data[MS_SRESET]) |=> $stable(ctrl.modulator_rate_select)
    ) else $error("reserved modulator code changed the rate");
    a_pcm_flag_gated: assert property (
        (!ctrl.bitstream_interface_enable && !ctrl.pcm_zero_flag_enable) [*2]
            |=> (left_bitstream_pin_out == 1'b0 && right_bitstream_pin_out == 1'b0)
    ) else $error("pcm zero flag shown while disabled");
    a_mute_ramp_floor: assert property (
        (soft_mute_request && mute_ramp_level == 8'h00 && !soft_now) |=>
            mute_ramp_level == 8'h00
    ) else $error("mute ramp left full mute while muting");
    a_readback_drive: assert property (
        $rose(ctl_data_oe) |-> st.rd
    ) else $error("data out driven for a write word");

    c_write_word: cover property (wr_now);
    c_read_back: cover property ($fell(ctl_data_oe));
    c_zero_mute: cover property ($rose(zero_detect_mute));
    c_ramp_bottom: cover property (mute_ramp_level == 8'h00);
endmodule
`default_nettype wire

// File: audio_dac_mode_pkg.sv
// constants, field layouts and carrier types of the mode control register bank
// assumes a single 100 MHz system clock and an active-high asynchronous reset
`default_nettype none
package audio_dac_mode_pkg;
    // clock rate and long timing
    localparam int unsigned CLK_FREQ_KHZ        = 100_000;
    localparam int unsigned PATTERN_HOLD_MS     = 200;
    localparam int unsigned PATTERN_HOLD_CYCLES = PATTERN_HOLD_MS * CLK_FREQ_KHZ;
    localparam int unsigned TIMER_W             = 25;
    // register indices carried in bits 14:8 of a control word
    localparam logic [6:0] IDX_OUTPUT_CONTROL   = 7'h13;
    localparam logic [6:0] IDX_MODE_SELECT_B    = 7'h14;
    localparam logic [6:0] IDX_ZERO_FLAG_CONFIG = 7'h15;
    localparam logic [6:0] IDX_ZERO_FLAG_STATUS = 7'h16;
    // values after reset
    localparam logic [7:0] RST_OUTPUT_CONTROL   = 8'h00;
    localparam logic [7:0] RST_MODE_SELECT_B    = 8'h00;
    localparam logic [7:0] RST_ZERO_FLAG_CONFIG = 8'h01;
    // control word layout
    localparam int unsigned WORD_DIR_BIT  = 15;
    localparam logic [4:0]  CNT_HEAD_LAST = 5'h07;
    localparam logic [4:0]  CNT_WORD_LAST = 5'h0f;
    localparam logic [4:0]  CNT_DATA_FIRST = 5'h08;
    // field positions
    localparam int unsigned OC_PHASE   = 7;
    localparam int unsigned OC_RATE    = 5;
    localparam int unsigned OC_DISABLE = 4;
    localparam int unsigned OC_PINSEL  = 3;
    localparam int unsigned OC_STEREO  = 2;
    localparam int unsigned OC_ROLLOFF = 1;
    localparam int unsigned OC_ZMUTE   = 0;
    localparam int unsigned MS_SRESET  = 6;
    localparam int unsigned MS_BSTREAM = 5;
    localparam int unsigned MS_EXTFILT = 4;
    localparam int unsigned MS_SINGLE  = 3;
    localparam int unsigned MS_MONOSRC = 2;
    localparam int unsigned MS_RATE    = 0;
    localparam int unsigned ZC_BSMODE  = 1;
    localparam int unsigned ZC_PCMEN   = 0;
    // codes and counts
    localparam logic [1:0]  RATE_RESERVED  = 2'h3;
    localparam logic [1:0]  BSZ_OFF        = 2'h0;
    localparam logic [10:0] ZERO_RUN       = 11'h400;
    localparam logic [7:0]  IDLE_PATTERN   = 8'h96;
    localparam logic [3:0]  BALANCED_ONES  = 4'h4;
    localparam logic [2:0]  GROUP_LAST     = 3'h7;
    localparam logic [7:0]  RAMP_TOP       = 8'hff;

    // serial port sequencer, gray along idle-shift-done
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_SHIFT = 2'b01,
        SER_DONE  = 2'b11
    } ser_state_t;

    // decoded operating settings handed to the converter core
    typedef struct packed {
        logic       output_phase_invert;
        logic [1:0] atten_step_rate;
        logic       output_disable;
        logic       zero_flag_pin_select;
        logic       bypass_stereo_select;
        logic       filter_rolloff_select;
        logic       zero_detect_mute_enable;
        logic       bitstream_interface_enable;
        logic       external_filter_bypass;
        logic       single_channel;
        logic       mono_source_channel;
        logic [1:0] modulator_rate_select;
        logic [1:0] bitstream_zero_flag_mode;
        logic       pcm_zero_flag_enable;
    } ctrl_t;
endpackage
`default_nettype wire

// File: host_ctl_model.sv
// host model for the four-wire control port, 16-bit words msb first
// assumes one caller of xfer at a time, paced by clk_sys
`default_nettype none
module host_ctl_model (
    input  wire logic clk_sys,
    input  wire logic ctl_data_out,
    input  wire logic ctl_data_oe,
    output var logic  ctl_clock = 1'b1,
    output var logic  ctl_select_n = 1'b1,
    output wire logic ctl_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv = 1'b0; // own data level
    // shared line, device wins while enabled
    assign ctl_data_in = ctl_data_oe ? ctl_data_out : drv;
    // phases of 8 clk, twice the minimum; clock stands still between words
    task automatic xfer(input logic [15:0] w, output logic [7:0] r);
        @(posedge clk_sys) #1 ctl_select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (8) @(posedge clk_sys);
            #1 ctl_clock = 1'b0;
            drv = w[i];
            repeat (8) @(posedge clk_sys);
            r[i % 8] = ctl_data_in;
            #1 ctl_clock = 1'b1;
        end
        repeat (8) @(posedge clk_sys);
        #1 ctl_select_n = 1'b1;
        drv = ~drv; // released line loses its last level
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: audio_dac_mode_control_regs_test.sv
// self-checking bench for the mode control register bank
// assumes host_ctl_model on the control port and a 100 MHz clk_sys
`default_nettype none
module audio_dac_mode_control_regs_test
    import audio_dac_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst = 1'b1, ctl_clock, ctl_select_n, ctl_data_in, ctl_data_out;
    logic ctl_data_oe, sample_frame_clock = 1'b0, soft_mute_request = 1'b0;
    // word clock idle; bitstream inputs driven by the groups task for bitstream flags
    logic filter_word_clock = 1'b0, bitstream_bit_clock = 1'b0;
    logic left_bitstream_pin_in = 1'b0, right_bitstream_pin_in = 1'b0;
    logic left_bitstream_pin_out, left_bitstream_pin_oe, right_bitstream_pin_out;
    logic right_bitstream_pin_oe, force_bipolar_zero, zero_detect_mute, soft_reset_pulse;
    logic atten_step_tick;
    logic [1:0] sample_zero = 2'h0, bitstream_clock_select;
    logic [7:0] mute_ramp_level, rd;
    ctrl_t ctrl;
    int num_errors = 0, cmp_count = 0, ticks = 0, pulses = 0;
    typedef struct packed {logic [6:0] a; logic [7:0] d, x;} row_t;
    // index, value written, value read back
    row_t rows [7] = '{
        '{7'h13, 8'hff, 8'hff},
        '{7'h13, 8'h00, 8'h00},
        '{7'h14, 8'hbe, 8'h3e},
        '{7'h14, 8'h03, 8'h02}, // frame clock stopped while 128x is set
        '{7'h15, 8'hff, 8'h07},
        '{7'h16, 8'hff, 8'h00},
        '{7'h20, 8'h5a, 8'h00}  // unmapped index reads zero
    };
    audio_dac_mode_control_regs #(.PATTERN_HOLD(25'h00c8)) audio_dac_mode_control_regs_i (.*);
    host_ctl_model host_ctl_model_i (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // watchdog: the run needs about 220 us
    initial begin
        #600us;
        num_errors++;
        summarize();
    end
    // count one-cycle pulses
    always @(posedge clk_sys) begin
        ticks += (atten_step_tick === 1'b1);
        pulses += (soft_reset_pulse === 1'b1);
    end
    task automatic check(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_ctl_model_i.xfer({1'b0, a, d}, rd);
    endtask
    task automatic rdx(input logic [6:0] a, input logic [7:0] x);
        host_ctl_model_i.xfer({1'b1, a, 8'h00}, rd);
        check(rd, x);
    endtask
    // n frame periods of 8 clk, then settle
    task automatic frames(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk_sys);
            #1 sample_frame_clock = ~sample_frame_clock;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    // n groups of byte b on both bitstream pins, msb first, 8 clk a bit
    task automatic groups(input int n, input logic [7:0] b);
        repeat (n) begin
            for (int i = 7; i >= 0; i--) begin
                repeat (4) @(posedge clk_sys);
                #1 bitstream_bit_clock = 1'b0;
                {left_bitstream_pin_in, right_bitstream_pin_in} = {2{b[i]}};
                repeat (4) @(posedge clk_sys);
                #1 bitstream_bit_clock = 1'b1;
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(ctrl, 32'h0000_0001);
        check(mute_ramp_level, 8'hff);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdx(rows[i].a, rows[i].x);
        end
        wr(7'h13, 8'h98);
        check({left_bitstream_pin_oe, right_bitstream_pin_oe, force_bipolar_zero,
            ctrl.output_phase_invert}, 4'hf);
        wr(7'h13, 8'h09);
        #1 sample_zero = 2'h3;
        frames(1023);
        rdx(7'h16, 8'h00);
        frames(2);
        check({left_bitstream_pin_out, right_bitstream_pin_out, zero_detect_mute,
            force_bipolar_zero}, 4'hf);
        rdx(7'h16, 8'h03);
        wr(7'h15, 8'h00);
        rdx(7'h16, 8'h00);
        check({left_bitstream_pin_out, right_bitstream_pin_out, zero_detect_mute}, 3'h1);
        wr(7'h15, 8'h01);
        wr(7'h14, 8'h25);
        check({ctrl.mono_source_channel, bitstream_clock_select, zero_detect_mute}, 4'h2);
        wr(7'h14, 8'h00);
        #1 sample_zero = 2'h0;
        frames(1);
        rdx(7'h16, 8'h00);
        wr(7'h13, 8'h60);
        frames(16);
        #1 ticks = 0;
        frames(64);
        check(ticks, 8);
        wr(7'h13, 8'h00);
        #1 soft_mute_request = 1'b1;
        frames(128);
        check(mute_ramp_level, 8'h7f);
        frames(200);
        check(mute_ramp_level, 8'h00);
        wr(7'h13, 8'hff);
        #1 pulses = 0;
        wr(7'h14, 8'h40);
        wr(7'h14, 8'h00);
        check(pulses, 1);
        check(ctrl, 32'h0000_0001);
        rdx(7'h14, 8'h00);
        wr(7'h15, 8'h03);
        wr(7'h14, 8'h20);
        groups(2, 8'ha5);
        rdx(7'h16, 8'h03);
        wr(7'h15, 8'h05);
        groups(5, 8'h96);
        rdx(7'h16, 8'h03);
        groups(1, 8'ha5);
        rdx(7'h16, 8'h00);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        check({ctrl, mute_ramp_level}, {15'h0001, 8'hff});
        summarize();
    end
endmodule
`default_nettype wire
